// ### core/mfa_flash_host.sv
// Host end: makes chip select and serial clock, sends command, address,
// mode and dummy clocks, then collects read bytes.
// Assumes the flash end samples on rising and drives on falling edges.
`default_nettype none
module mfa_flash_host
  import mfa_pkg::*;
#(
  parameter int HALF = LINK_HALF_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  mfa_link_if.host LINK,
  input wire logic I_START,
  input wire logic [1:0] I_KIND,
  input wire logic I_SKIP_CMD,
  input wire logic [23:0] I_ADDR,
  input wire logic [7:0] I_MODE,
  input wire logic [3:0] I_DUMMY_CLKS,
  input wire logic [15:0] I_LEN,
  output logic O_BUSY,
  output logic [7:0] O_DATA,
  output logic O_DATA_VALID,
  output logic O_DONE
);
  // Sync delay plus device reaction must fit inside half a clock
  if (HALF < 6 || HALF > 255) begin : g_chk
    $error("HALF must lie in 6..255");
  end

  typedef struct packed {
    mfa_host_e state;
    mfa_kind_e kind;
    logic cs_n;
    logic sclk;
    logic [7:0] div;
    logic [5:0] cnt;
    logic [15:0] rem;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [5:0] dummy_last;
    logic [7:0] sh;
    logic [3:0] io_m;
    logic [3:0] io_s;
    logic [3:0] out;
    logic [3:0] oe;
    logic [7:0] data;
    logic valid;
    logic done;
    logic busy;
  } mfa_host_s;

  mfa_host_s r;
  mfa_host_s next_r;
  logic tick;
  logic fetch;

  assign tick = (r.div == 8'(HALF - 1));
  assign fetch = (r.kind == K_FETCH) || (r.kind == K_FETCH_AL);

  // Line values for the next clock of a phase: {oe, out}
  function automatic logic [7:0] drive(input mfa_host_e st, input mfa_kind_e k,
                                       input logic [5:0] c, input logic [23:0] a,
                                       input logic [7:0] m);
    logic [7:0] cmd;
    logic [7:0] cs;
    logic [23:0] as;
    logic f;
    cmd = (k == K_DUAL) ? CMD_DUAL : (k == K_QUAD) ? CMD_QUAD :
          (k == K_FETCH) ? CMD_FETCH : CMD_FETCH_AL;
    f = (k == K_FETCH) || (k == K_FETCH_AL);
    cs = cmd << c[2:0];
    as = f ? (a << {c[2:0], 2'b00}) : (a << c[4:0]);
    drive = 8'h00;
    case (st)
      HS_CMD: drive = {4'h1, 3'h0, cs[7]};
      HS_ADDR: drive = f ? {4'hF, as[23:20]} : {4'h1, 3'h0, as[23]};
      HS_DUMMY: begin
        if (f && c < MODE_CLKS) begin
          drive = {4'hF, (c == 6'h00) ? m[7:4] : m[3:0]};
        end else if (!f) begin
          drive = 8'h10; // Dummy byte held low on line 0
        end
      end
      default: drive = 8'h00;
    endcase
  endfunction : drive

  // Next-state logic: divider, phase sequencing, data capture
  always_comb begin
    next_r = r;
    next_r.io_m = LINK.io;
    next_r.io_s = r.io_m;
    next_r.valid = 1'b0;
    next_r.done = 1'b0;
    if (r.state == HS_IDLE) begin
      next_r.div = 8'h00;
      if (I_START && I_LEN != 16'h0000) begin
        next_r.kind = mfa_kind_e'(I_KIND);
        next_r.addr = I_ADDR;
        next_r.mode = I_MODE;
        next_r.rem = I_LEN;
        next_r.dummy_last = (I_KIND[1] ? {2'b00, I_DUMMY_CLKS} : 6'h08) - 6'h01;
        next_r.state = (I_SKIP_CMD && I_KIND[1]) ? HS_ADDR : HS_CMD;
        next_r.cnt = 6'h00;
        next_r.cs_n = 1'b0;
        next_r.busy = 1'b1;
        {next_r.oe, next_r.out} = drive(next_r.state, next_r.kind, 6'h00, I_ADDR, I_MODE);
      end
    end else if (!tick) begin
      next_r.div = r.div + 8'h01;
    end else begin
      next_r.div = 8'h00;
      if (r.sclk) begin
        next_r.sclk = 1'b0;
        if (r.state != HS_END) begin
          {next_r.oe, next_r.out} = drive(r.state, r.kind, r.cnt, r.addr, r.mode);
        end
      end else if (r.state == HS_END) begin
        next_r.cs_n = 1'b1;
        next_r.oe = 4'h0;
        next_r.done = 1'b1;
        next_r.busy = 1'b0;
        next_r.state = HS_IDLE;
      end else begin
        // Rising edge: device samples our bits, we sample its data
        next_r.sclk = 1'b1;
        next_r.cnt = r.cnt + 6'h01;
        case (r.state)
          HS_CMD: begin
            if (r.cnt == CMD_LAST) begin
              next_r.state = HS_ADDR;
              next_r.cnt = 6'h00;
            end
          end
          HS_ADDR: begin
            if (r.cnt == (fetch ? ADDR_QUAD_LAST : ADDR_SER_LAST)) begin
              next_r.state = HS_DUMMY;
              next_r.cnt = 6'h00;
            end
          end
          HS_DUMMY: begin
            if (r.cnt == r.dummy_last) begin
              next_r.state = HS_DATA;
              next_r.cnt = 6'h00;
            end
          end
          HS_DATA: begin
            next_r.sh = (r.kind == K_DUAL) ? {r.sh[5:0], r.io_s[1:0]} : {r.sh[3:0], r.io_s};
            if (r.cnt[1:0] == ((r.kind == K_DUAL) ? DUAL_POS_LAST : QUAD_POS_LAST)) begin
              next_r.cnt = 6'h00;
              next_r.data = next_r.sh;
              next_r.valid = 1'b1;
              next_r.rem = r.rem - 16'h0001;
              if (r.rem == 16'h0001) begin
                next_r.state = HS_END;
              end
            end
          end
          default: next_r.state = HS_IDLE;
        endcase
      end
    end
  end

  // State register; select idles high
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      r <= '0;
      r.cs_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.cs_n = r.cs_n;
  assign LINK.sclk = r.sclk;
  assign LINK.host_io_out = r.out;
  assign LINK.host_io_oe = r.oe;
  assign O_BUSY = r.busy;
  assign O_DATA = r.data;
  assign O_DATA_VALID = r.valid;
  assign O_DONE = r.done;
endmodule : mfa_flash_host
`default_nettype wire

// ### core/mfa_pkg.sv
// Shared constants and state types for the multi-line flash read path.
// Assumes both link ends run on one 50 MHz core clock domain each.
`default_nettype none
package mfa_pkg;
  // Core clock and link timing
  localparam int CORE_CLK_NS = 20;
  localparam int LINK_HALF_NS = 160;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  // Command codes
  localparam logic [7:0] CMD_DUAL = 8'h3B;
  localparam logic [7:0] CMD_QUAD = 8'h6B;
  localparam logic [7:0] CMD_FETCH = 8'hEB;
  localparam logic [7:0] CMD_FETCH_AL = 8'hE7;
  // Phase lengths in serial clocks (last index = count - 1)
  localparam logic [5:0] CMD_LAST = 6'h07;
  localparam logic [5:0] ADDR_SER_LAST = 6'h17;
  localparam logic [5:0] ADDR_QUAD_LAST = 6'h05;
  localparam logic [5:0] DUMMY_FIX_LAST = 6'h07;
  localparam logic [5:0] MODE_CLKS = 6'h02;
  localparam logic [1:0] DUAL_POS_LAST = 2'h3;
  localparam logic [1:0] QUAD_POS_LAST = 2'h1;
  // Dummy select field: clocks = 2 * (code + 1), codes above MAX clamp
  localparam logic [2:0] DUMMY_SEL_MAX = 3'h4;
  // Mode field bits [5:4] equal to this keep continuous fetch
  localparam logic [1:0] MODE_KEEP = 2'h2;
  localparam logic [23:0] ADDR_RESET = 24'h00_0000;

  typedef enum logic [2:0] {DS_IDLE, DS_CMD, DS_ADDR, DS_DUMMY, DS_DATA, DS_IGNORE} mfa_dev_e;
  typedef enum logic [1:0] {K_DUAL, K_QUAD, K_FETCH, K_FETCH_AL} mfa_kind_e;
  typedef enum logic [2:0] {HS_IDLE, HS_CMD, HS_ADDR, HS_DUMMY, HS_DATA, HS_END} mfa_host_e;
endpackage : mfa_pkg
`default_nettype wire

// ### core/mfa_link_if.sv
// Serial link between host and flash: select, clock, four data lines.
// Each end gives out/enable per line; the wire level is resolved here
// with a weak pull-up when nobody drives.
`default_nettype none
interface mfa_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;   // [3] hold_io3_pin, [2] protect_io2_pin, [1] serial_out_io1, [0] serial_in_io0

  // Wire resolution; device wins if both drive (contention is a bench error)
  genvar g;
  for (g = 0; g < 4; g++) begin : g_wire
    assign io[g] = dev_io_oe[g] ? dev_io_out[g] : (host_io_oe[g] ? host_io_out[g] : 1'b1);
  end

  modport dev (input cs_n, input sclk, input io, output dev_io_out, output dev_io_oe);
  modport host (output cs_n, output sclk, output host_io_out, output host_io_oe, input io);
endinterface : mfa_link_if
`default_nettype wire

// ### core/mfa_flash_dev.sv
// Flash end: decodes dual, quad and quad-address fetch reads and streams
// array bytes out on two or four lines.
// Assumes select and serial clock come from the host, unsynchronised;
// the array is filled through a plain load port on the core clock.
`default_nettype none
module mfa_flash_dev
  import mfa_pkg::*;
#(
  parameter int MEM_AW = 20
) (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  mfa_link_if.dev LINK,
  input wire logic I_QUAD_ENABLE,
  input wire logic I_ALIGNED_SELECT,
  input wire logic [2:0] I_DUMMY_SELECT,
  input wire logic I_LOAD_WE,
  input wire logic [MEM_AW-1:0] I_LOAD_ADDR,
  input wire logic [7:0] I_LOAD_DATA,
  output logic O_CONT_MODE
);
  // Array size must fit the 24-bit address field
  if (MEM_AW < 4 || MEM_AW > 24) begin : g_chk
    $error("MEM_AW must lie in 4..24");
  end

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic [3:0] io_m;
    logic [3:0] io_s;
    mfa_dev_e state;
    mfa_kind_e kind;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [7:0] sh;
    logic cont;
    logic cont_al;
    logic [3:0] out;
    logic [3:0] oe;
  } mfa_dev_s;

  mfa_dev_s r;
  mfa_dev_s next_r;
  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic [7:0] mem_rd;
  logic rise;
  logic fall;
  logic fetch;
  logic [7:0] cmd_in;
  logic [23:0] addr_in;
  logic [5:0] dummy_last;
  logic [7:0] cur;
  logic [MEM_AW-1:0] idx_next;

  // Edges seen on the second synchroniser stage only
  assign rise = r.sclk_s & ~r.sclk_d;
  assign fall = ~r.sclk_s & r.sclk_d;
  assign fetch = (r.kind == K_FETCH) || (r.kind == K_FETCH_AL);
  assign cmd_in = {r.cmd[6:0], r.io_s[0]};
  assign addr_in = fetch ? {r.addr[19:0], r.io_s} : {r.addr[22:0], r.io_s[0]};
  // fetch: programmed dummy count, mode clocks included; fixed count otherwise
  assign dummy_last = fetch ?
      {2'b00, ((I_DUMMY_SELECT > DUMMY_SEL_MAX) ? DUMMY_SEL_MAX : I_DUMMY_SELECT), 1'b1}
      : DUMMY_FIX_LAST;
  assign mem_rd = mem[r.addr[MEM_AW-1:0]];
  assign cur = (r.cnt == 6'h00) ? mem_rd : r.sh;
  // index rolls over at the top with no gap
  assign idx_next = r.addr[MEM_AW-1:0] + 1'b1;

  // Array load port; contents are not reset
  always_ff @(posedge I_CORE_CLK) begin
    if (I_LOAD_WE) begin
      mem[I_LOAD_ADDR] <= I_LOAD_DATA;
    end
  end

  // Next-state logic: synchronisers, command decode, data shifter
  always_comb begin
    next_r = r;
    next_r.sclk_m = LINK.sclk;
    next_r.sclk_s = r.sclk_m;
    next_r.sclk_d = r.sclk_s;
    next_r.cs_m = LINK.cs_n;
    next_r.cs_s = r.cs_m;
    next_r.io_m = LINK.io;
    next_r.io_s = r.io_m;
    if (r.cs_s) begin
      // deselect at any point floats every line
      next_r.state = DS_IDLE;
      next_r.oe = 4'h0;
      next_r.cnt = 6'h00;
    end else if (r.state == DS_IDLE) begin
      // continuous fetch starts straight at the address
      next_r.cnt = 6'h00;
      next_r.state = r.cont ? DS_ADDR : DS_CMD;
      next_r.kind = r.cont_al ? K_FETCH_AL : K_FETCH;
    end else if (rise) begin
      // host bits taken on the rising edge
      next_r.cnt = r.cnt + 6'h01;
      case (r.state)
        DS_CMD: begin
          next_r.cmd = cmd_in;
          if (r.cnt == CMD_LAST) begin
            next_r.cnt = 6'h00;
            next_r.state = DS_ADDR;
            case (cmd_in)
              CMD_DUAL: next_r.kind = K_DUAL;
              CMD_QUAD: begin
                next_r.kind = K_QUAD;
                next_r.state = I_QUAD_ENABLE ? DS_ADDR : DS_IGNORE;
              end
              CMD_FETCH: next_r.kind = K_FETCH;
              CMD_FETCH_AL: next_r.kind = K_FETCH_AL;
              default: next_r.state = DS_IGNORE;
            endcase
          end
        end
        DS_ADDR: begin
          next_r.addr = addr_in;
          if (r.cnt == (fetch ? ADDR_QUAD_LAST : ADDR_SER_LAST)) begin
            next_r.cnt = 6'h00;
            next_r.state = DS_DUMMY;
            // aligned fetch drops the low two bits
            if (r.kind == K_FETCH_AL || (r.kind == K_FETCH && I_ALIGNED_SELECT)) begin
              next_r.addr = {addr_in[23:2], 2'b00};
            end
          end
        end
        DS_DUMMY: begin
          // mode field rides the first two dummy clocks
          if (fetch && r.cnt < MODE_CLKS) begin
            next_r.mode = {r.mode[3:0], r.io_s};
          end
          // data starts after the last dummy clock
          if (r.cnt == dummy_last) begin
            next_r.cnt = 6'h00;
            next_r.state = DS_DATA;
            if (fetch) begin
              // Shortest dummy count ends on the low nibble clock itself
              next_r.cont = (next_r.mode[5:4] == MODE_KEEP);
              next_r.cont_al = (r.kind == K_FETCH_AL);
            end
          end
        end
        default: next_r.cnt = r.cnt;
      endcase
    end else if (fall && r.state == DS_DATA) begin
      // outputs change on the falling edge
      if (r.cnt == 6'h00) begin
        next_r.addr = ADDR_RESET;
        next_r.addr[MEM_AW-1:0] = idx_next;
      end
      if (r.kind == K_DUAL) begin
        // line 0 turned round for dual data
        next_r.oe = 4'h3;
        // odd bit on line 1, even on line 0
        next_r.out = {2'b00, cur[7:6]};
        next_r.sh = {cur[5:0], 2'b00};
        next_r.cnt = (r.cnt[1:0] == DUAL_POS_LAST) ? 6'h00 : r.cnt + 6'h01;
      end else begin
        // all four lines, 3 to 0, become outputs
        next_r.oe = 4'hF;
        // high nibble first, bit 7 on line 3
        next_r.out = cur[7:4];
        next_r.sh = {cur[3:0], 4'h0};
        next_r.cnt = (r.cnt[1:0] == QUAD_POS_LAST) ? 6'h00 : r.cnt + 6'h01;
      end
    end
  end

  // State register; select synchroniser resets to deselected
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      r <= '0;
      r.cs_m <= 1'b1;
      r.cs_s <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign LINK.dev_io_out = r.out;
  assign LINK.dev_io_oe = r.oe;
  assign O_CONT_MODE = r.cont;
endmodule : mfa_flash_dev
`default_nettype wire

// ### bench/mfa_link_assertions.sv
// Checker for the flash link: select, serial clock and line enables.
// Assumes one core clock domain and the ends sampling pins via flops.
`default_nettype none
module mfa_link_assertions (
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_host_io_oe,
  input wire logic [3:0] i_dev_io_out,
  input wire logic [3:0] i_dev_io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  // Release and idle behaviour around select
  property p_release; $rose(i_cs_n) |-> ##[1:5] i_dev_io_oe == 4'h0; endproperty
  a_release: assert property (p_release) else $error("lines kept after select");
  property p_idle; i_cs_n [*6] |-> i_dev_io_oe == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("flash drives while idle");
  property p_sclk_idle; i_cs_n |-> !i_sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock high while idle");

  // Line turnaround: only two-line or four-line sets, never a clash
  property p_oe_kind; i_dev_io_oe inside {4'h0, 4'h3, 4'hF}; endproperty
  a_oe_kind: assert property (p_oe_kind) else $error("odd enable set");
  property p_no_clash; (i_dev_io_oe & i_host_io_oe) == 4'h0; endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive");

  // Outputs move only while the serial clock is low
  property p_drive_low;
    $changed(i_dev_io_out) && !i_cs_n && |i_dev_io_oe |-> !i_sclk;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data moved with clock high");
  property p_oe_rise; $rose(|i_dev_io_oe) |-> !i_sclk && !i_cs_n; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("turnaround at wrong time");

  // Once driving, the set stays until select rises
  property p_oe_hold;
    !i_cs_n && !$past(i_cs_n) && ($past(i_dev_io_oe) != 4'h0) |->
      i_dev_io_oe == $past(i_dev_io_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable dropped mid frame");

  // Main scenarios
  c_dual: cover property (i_dev_io_oe == 4'h3);
  c_quad: cover property (i_dev_io_oe == 4'hF);
  c_end: cover property ($rose(i_cs_n) && |i_dev_io_oe);
endmodule : mfa_link_assertions
`default_nettype wire

// ### bench/tb_top.sv
// Testbench: host and flash ends joined by the link, reads checked by value.
// Assumes a small array (MEM_AW 8) filled with address xor 5A.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, start, skip, busy, dvalid, done, qe, alsel, lwe, cont;
  logic [1:0] kind;
  logic [23:0] addr;
  logic [7:0] mode, data, laddr, ldata;
  logic [3:0] dclks, oe_seen;
  logic [15:0] len;
  logic [2:0] dsel;
  int miscompares = 0;
  int checks = 0;
  int c;

  mfa_link_if link();
  mfa_flash_host mfa_flash_host_inst (.I_CORE_CLK(clk), .I_NRST(rst_n), .LINK(link),
    .I_START(start), .I_KIND(kind), .I_SKIP_CMD(skip), .I_ADDR(addr), .I_MODE(mode),
    .I_DUMMY_CLKS(dclks), .I_LEN(len), .O_BUSY(busy), .O_DATA(data),
    .O_DATA_VALID(dvalid), .O_DONE(done));
  mfa_flash_dev #(.MEM_AW(8)) mfa_flash_dev_inst (.I_CORE_CLK(clk), .I_NRST(rst_n),
    .LINK(link), .I_QUAD_ENABLE(qe), .I_ALIGNED_SELECT(alsel), .I_DUMMY_SELECT(dsel),
    .I_LOAD_WE(lwe), .I_LOAD_ADDR(laddr), .I_LOAD_DATA(ldata), .O_CONT_MODE(cont));
  mfa_link_assertions mfa_link_assertions_inst (.I_CORE_CLK(clk), .I_NRST(rst_n),
    .i_cs_n(link.cs_n), .i_sclk(link.sclk), .i_host_io_oe(link.host_io_oe),
    .i_dev_io_out(link.dev_io_out), .i_dev_io_oe(link.dev_io_oe));

  // Core clock, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Collect which lines the flash drove during a frame
  always @(posedge clk) begin
    if (!link.cs_n) oe_seen <= oe_seen | link.dev_io_oe;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // One host read; expected bytes follow the fill pattern from byte address ea
  task automatic rd(input logic [1:0] k, input logic sk, input logic [23:0] a,
                    input logic [7:0] m, input logic [3:0] dc, input logic [15:0] n,
                    input logic [7:0] ea, input logic refuse, input logic [3:0] oe_exp);
    logic [15:0] got;
    int t;
    got = 16'h0000;
    oe_seen = 4'h0;
    kind = k;
    skip = sk;
    addr = a;
    mode = m;
    dclks = dc;
    len = n;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    check({7'h00, busy}, 8'h01);
    for (t = 0; t < 20000 && done !== 1'b1; t++) begin
      @(posedge clk);
      #1;
      if (dvalid === 1'b1) begin
        check(data, refuse ? 8'hFF : ((ea + got[7:0]) ^ 8'h5A));
        got++;
      end
    end
    check(got[7:0], n[7:0]);
    check({7'h00, busy}, 8'h00);
    check({4'h0, oe_seen}, {4'h0, oe_exp});
    repeat (6) @(posedge clk);
    #1;
    check({4'h0, link.dev_io_oe}, 8'h00);
  endtask : rd

  // Reset, fill the array, then the read sequence
  initial begin
    {rst_n, start, skip, qe, alsel, lwe} = 6'h00;
    {kind, addr, mode, dclks, len, dsel, laddr, ldata} = '0;
    oe_seen = 4'h0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    for (c = 0; c < 256; c++) begin
      lwe = 1'b1;
      laddr = c[7:0];
      ldata = c[7:0] ^ 8'h5A;
      @(posedge clk);
      #1;
    end
    lwe = 1'b0;
    rd(2'h0, 1'b0, 24'h00_00FE, 8'h00, 4'h8, 16'h0004, 8'hFE, 1'b0, 4'h3);
    qe = 1'b1;
    rd(2'h1, 1'b0, 24'h00_0010, 8'h00, 4'h8, 16'h0003, 8'h10, 1'b0, 4'hF);
    qe = 1'b0;
    rd(2'h1, 1'b0, 24'h00_0010, 8'h00, 4'h8, 16'h0002, 8'h10, 1'b1, 4'h0);
    qe = 1'b1;
    // Dummy codes 0 to 4, then code 7 beyond the table clamping to ten
    for (c = 0; c < 6; c++) begin
      dsel = (c == 5) ? 3'h7 : c[2:0];
      rd(2'h2, 1'b0, 24'h00_0023, 8'h00, (c > 4) ? 4'hA : 4'(2 * (c + 1)), 16'h0002,
         8'h23, 1'b0, 4'hF);
    end
    dsel = 3'h2;
    rd(2'h2, 1'b0, 24'h00_00FF, 8'h20, 4'h6, 16'h0003, 8'hFF, 1'b0, 4'hF);
    check({7'h00, cont}, 8'h01);
    rd(2'h2, 1'b1, 24'h00_0041, 8'h00, 4'h6, 16'h0002, 8'h41, 1'b0, 4'hF);
    check({7'h00, cont}, 8'h00);
    rd(2'h3, 1'b0, 24'h00_0047, 8'h00, 4'h6, 16'h0002, 8'h44, 1'b0, 4'hF);
    alsel = 1'b1;
    rd(2'h2, 1'b0, 24'h00_0086, 8'h00, 4'h6, 16'h0002, 8'h84, 1'b0, 4'hF);
    alsel = 1'b0;
    rd(2'h2, 1'b0, 24'h00_0086, 8'h00, 4'h6, 16'h0002, 8'h86, 1'b0, 4'hF);
    finish_test();
  end

  // Hang guard, about four times the expected run of some 7000 cycles
  initial begin
    #600_000;
    miscompares++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
